// File: include/isar_pkg.sv
// constants, codes and state layout for the i2c slave address receive block
// assumes one 20 MHz system clock; scl and sda arrive unsynchronised from pins
package isar_pkg;

   // mode field codes of control_reg_one
   localparam logic [3:0] ISAR_MODE_SLV7     = 4'h6;
   localparam logic [3:0] ISAR_MODE_SLV10    = 4'h7;
   localparam logic [3:0] ISAR_MODE_MASTER   = 4'h8;
   localparam logic [3:0] ISAR_MODE_FW_MST   = 4'hb;
   localparam logic [3:0] ISAR_MODE_SLV7_SS  = 4'he;
   localparam logic [3:0] ISAR_MODE_SLV10_SS = 4'hf;

   // address layout
   localparam logic [4:0] ISAR_TENBIT_HDR  = 5'h1e;  // 11110
   localparam int         ISAR_RW_POS      = 0;
   localparam logic [3:0] ISAR_BITS_BYTE   = 4'h8;
   localparam logic [3:0] ISAR_CNT_RST     = 4'h0;
   localparam logic [7:0] ISAR_BYTE_RST    = 8'h00;
   localparam logic [2:0] ISAR_SYNC_RST    = 3'h7;   // idle bus is high

   typedef enum logic [2:0] {
      ISAR_ST_IDLE   = 3'b000,
      ISAR_ST_RX     = 3'b001,
      ISAR_ST_RXACK  = 3'b010,
      ISAR_ST_HOLDUA = 3'b011,
      ISAR_ST_TXWAIT = 3'b100,
      ISAR_ST_TX     = 3'b101,
      ISAR_ST_TXACK  = 3'b110
   } isar_state_e;

   typedef enum logic [1:0] {
      ISAR_K_FIRST = 2'b00,
      ISAR_K_LOW   = 2'b01,
      ISAR_K_DATA  = 2'b10
   } isar_kind_e;

   // pin pair carrier
   typedef struct packed {
      logic scl;
      logic sda;
   } isar_pins_s;

   // whole block state
   typedef struct packed {
      isar_state_e st;
      isar_kind_e  kind;
      logic [2:0]  scl_sy;
      logic [2:0]  sda_sy;
      isar_pins_s  filt;
      logic [7:0]  sr;
      logic [3:0]  cnt;
      logic [7:0]  buf_r;
      logic [7:0]  own;
      logic        bf;
      logic        ov;
      logic        irq;
      logic        ua;
      logic        rw;
      logic        clock_release;
      logic        match;
      logic        irq_pend;
      logic        tenbit_ok;
      logic        mst_ack;
      isar_pins_s  oe;
      isar_pins_s  lvl;
   } isar_regs_s;

endpackage : isar_pkg

// File: src/isar_slave.sv
// i2c slave: address match, auto ack, buffer handling, 10-bit sequence
// assumes firmware strobes are one-cycle pulses on clk_in; scl/sda from pins
//
// Overview of operation
// - bus side does nothing until port_enable is set; firmware writes still take effect
// - mode field picks master, 7/10-bit slave, start/stop variants, fw master
// - pins driven open-drain only when enabled, i2c mode and pins set as inputs
// - as slave-transmitter the block drives its data onto sda
// - address match raises the flag; start/stop modes also flag start and stop
// - match or data byte after match: auto ack and copy shift reg to buffer
// - buffer_full or overflow already set: no ack, buffer kept, flag still set
// - reading buffer clears buffer_full; overflow cleared only by firmware
// - after enable wait for start, shift eight bits on scl rising edges
// - compare shift bits 7:1 with own address at eighth scl falling edge
// - on clean match: load buffer, set full, ack, flag at ninth falling edge
// - 10-bit first byte is 11110, two high address bits, then r/w
// - first 10-bit byte sets flag, buffer_full and address_update_needed
// - own address write clears address_update_needed and frees a held scl
// - low byte sets flag, full, update; scl held only on address match
// - after repeated start, high byte with read sets flag, full and r/w
// - firmware write to buffer sets buffer_full, then transmit proceeds
// - firmware sets clock_release; block then frees its hold on scl
module isar_slave
   import isar_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       port_enable_in,
   input  wire logic [3:0] mode_in,
   input  wire logic       pin_dir_scl_in,
   input  wire logic       pin_dir_sda_in,
   input  wire logic       own_addr_wr_in,
   input  wire logic [7:0] own_addr_data_in,
   input  wire logic       buf_rd_in,
   input  wire logic       buf_wr_in,
   input  wire logic [7:0] buf_wdata_in,
   input  wire logic       ov_clr_in,
   input  wire logic       irq_clr_in,
   input  wire logic       clock_release_set_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe_out,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic [7:0]      transfer_buffer_out,
   output logic [7:0]      own_address_out,
   output logic            buffer_full_out,
   output logic            receive_overflow_out,
   output logic            irq_flag_out,
   output logic            addr_update_out,
   output logic            rw_status_out,
   output logic            clock_release_out
);

   isar_regs_s q;
   isar_regs_s d;

   // mode decode
   logic slave_mode;
   logic ten_mode;
   logic ss_mode;
   logic any_mode;
   logic active;
   logic drive_ok;
   assign slave_mode = (mode_in == ISAR_MODE_SLV7) || (mode_in == ISAR_MODE_SLV10) ||
                       (mode_in == ISAR_MODE_SLV7_SS) || (mode_in == ISAR_MODE_SLV10_SS);
   assign ten_mode   = (mode_in == ISAR_MODE_SLV10) || (mode_in == ISAR_MODE_SLV10_SS);
   assign ss_mode    = (mode_in == ISAR_MODE_SLV7_SS) || (mode_in == ISAR_MODE_SLV10_SS);
   assign any_mode   = slave_mode || (mode_in == ISAR_MODE_MASTER) ||
                       (mode_in == ISAR_MODE_FW_MST);
   assign active     = port_enable_in && slave_mode;
   assign drive_ok   = port_enable_in && any_mode && pin_dir_scl_in && pin_dir_sda_in;

   // next-state logic
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic hi_ok;
      logic clean;
      logic [3:0] cnt_n;
      // per-cycle edge and condition flags, cleared before use
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c  = 1'b0;
      stop_c   = 1'b0;
      hi_ok    = 1'b0;
      clean    = 1'b0;
      cnt_n    = ISAR_CNT_RST;
      d = q;

      // pin synchronisers, change accepted once stages two and three agree
      d.scl_sy = {q.scl_sy[1:0], scl_in};
      d.sda_sy = {q.sda_sy[1:0], sda_in};
      if (q.scl_sy[1] == q.scl_sy[2]) begin
         d.filt.scl = q.scl_sy[2];
      end
      if (q.sda_sy[1] == q.sda_sy[2]) begin
         d.filt.sda = q.sda_sy[2];
      end
      scl_rise = d.filt.scl && !q.filt.scl;
      scl_fall = !d.filt.scl && q.filt.scl;
      start_c  = q.filt.scl && d.filt.scl && q.filt.sda && !d.filt.sda;
      stop_c   = q.filt.scl && d.filt.scl && !q.filt.sda && d.filt.sda;

      // firmware side clears first, so a hardware set below wins
      if (buf_rd_in) begin
         d.bf = 1'b0;
      end
      if (ov_clr_in) begin
         d.ov = 1'b0;
      end
      if (irq_clr_in) begin
         d.irq = 1'b0;
      end
      if (own_addr_wr_in) begin
         d.own = own_addr_data_in;
         d.ua  = 1'b0;
      end
      if (buf_wr_in) begin
         d.buf_r = buf_wdata_in;
         d.bf    = 1'b1;
      end
      if (clock_release_set_in) begin
         d.clock_release = 1'b1;
      end

      // bus sequencing
      if (!active) begin
         d.st        = ISAR_ST_IDLE;
         d.tenbit_ok = 1'b0;
      end else if (start_c) begin
         d.st   = ISAR_ST_RX;
         d.kind = ISAR_K_FIRST;
         d.cnt  = ISAR_CNT_RST;
         d.oe   = '0;
         if (ss_mode) begin
            d.irq = 1'b1;
         end
      end else if (stop_c) begin
         d.st        = ISAR_ST_IDLE;
         d.tenbit_ok = 1'b0;
         if (ss_mode) begin
            d.irq = 1'b1;
         end
      end else begin
         unique case (q.st)
            ISAR_ST_IDLE: begin
               // nothing driven between frames
               d.oe = '0;
            end
            ISAR_ST_RX: begin
               if (scl_rise && q.cnt < ISAR_BITS_BYTE) begin
                  d.sr  = {q.sr[6:0], d.filt.sda};
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == ISAR_BITS_BYTE) begin
                  // eighth falling edge: compare and decide on ack
                  clean = !q.bf && !q.ov;
                  hi_ok = (q.sr[7:3] == ISAR_TENBIT_HDR) &&
                          (q.sr[2:1] == q.own[2:1]);
                  d.irq_pend = 1'b0;
                  d.match    = 1'b0;
                  unique case (q.kind)
                     ISAR_K_FIRST: begin
                        if (!ten_mode) begin
                           d.match = q.sr[7:1] == q.own[7:1];
                        end else if (!q.sr[ISAR_RW_POS]) begin
                           d.match = hi_ok;
                        end else begin
                           d.match = hi_ok && q.tenbit_ok;
                        end
                        if (d.match) begin
                           d.irq_pend = 1'b1;
                           d.rw = q.sr[ISAR_RW_POS];
                           if (ten_mode && !q.sr[ISAR_RW_POS]) begin
                              d.ua = 1'b1;
                           end
                        end
                     end
                     ISAR_K_LOW: begin
                        d.match    = q.sr == q.own;
                        d.irq_pend = 1'b1;
                        d.ua       = 1'b1;
                     end
                     default: begin
                        d.match    = 1'b1;
                        d.irq_pend = 1'b1;
                     end
                  endcase
                  if ((d.match || q.kind == ISAR_K_LOW) && clean) begin
                     d.buf_r = q.sr;
                     d.bf    = 1'b1;
                  end
                  // data refused while the last byte is unread also marks overflow
                  if (q.kind == ISAR_K_DATA && q.bf) begin
                     d.ov = 1'b1;
                  end
                  d.oe.sda = d.match && clean;
                  if (!d.match && q.kind == ISAR_K_FIRST) begin
                     d.st = ISAR_ST_IDLE;
                  end else begin
                     d.match = d.match && clean;
                     d.st    = ISAR_ST_RXACK;
                  end
               end
            end
            ISAR_ST_RXACK: begin
               if (scl_fall) begin
                  // ninth falling edge: release sda, raise the flag
                  d.oe.sda = 1'b0;
                  if (q.irq_pend) begin
                     d.irq = 1'b1;
                  end
                  d.cnt = ISAR_CNT_RST;
                  if (!q.match) begin
                     d.st = ISAR_ST_IDLE;
                  end else if (q.kind == ISAR_K_FIRST && q.rw) begin
                     d.clock_release = 1'b0;
                     d.st  = ISAR_ST_TXWAIT;
                  end else if (q.kind == ISAR_K_FIRST && ten_mode) begin
                     d.kind = ISAR_K_LOW;
                     d.st   = ISAR_ST_HOLDUA;
                  end else if (q.kind == ISAR_K_LOW) begin
                     d.tenbit_ok = 1'b1;
                     d.kind      = ISAR_K_DATA;
                     d.st        = ISAR_ST_HOLDUA;
                  end else begin
                     d.kind = ISAR_K_DATA;
                     d.st   = ISAR_ST_RX;
                  end
               end
            end
            // scl stays low until firmware reloads the own address
            ISAR_ST_HOLDUA: begin
               if (!d.ua) begin
                  d.st = ISAR_ST_RX;
               end
            end
            // load only with the clock released and scl low, so bit 7 gets a low phase
            ISAR_ST_TXWAIT: begin
               if (q.clock_release && !d.filt.scl) begin
                  d.sr     = q.buf_r;
                  d.bf     = 1'b0;
                  d.oe.sda = !q.buf_r[7];
                  d.cnt    = ISAR_CNT_RST;
                  d.st     = ISAR_ST_TX;
               end
            end
            // next bit after each falling edge; ack slot after the eighth
            ISAR_ST_TX: begin
               if (scl_fall) begin
                  cnt_n = q.cnt + 4'h1;
                  d.cnt = cnt_n;
                  if (cnt_n == ISAR_BITS_BYTE) begin
                     d.oe.sda = 1'b0;
                     d.st     = ISAR_ST_TXACK;
                  end else begin
                     d.sr     = {q.sr[6:0], 1'b0};
                     d.oe.sda = !q.sr[6];
                  end
               end
            end
            // master ack taken on the rise; a nack ends the transfer
            ISAR_ST_TXACK: begin
               if (scl_rise) begin
                  d.mst_ack = !d.filt.sda;
               end else if (scl_fall) begin
                  d.irq = 1'b1;
                  if (q.mst_ack) begin
                     d.clock_release = 1'b0;
                     d.st  = ISAR_ST_TXWAIT;
                  end else begin
                     d.st = ISAR_ST_IDLE;
                  end
               end
            end
            default: begin
               d.st = ISAR_ST_IDLE;
            end
         endcase
      end

      // scl hold while waiting on firmware
      d.oe.scl = (d.st == ISAR_ST_HOLDUA) ||
                 (d.st == ISAR_ST_TXWAIT && !d.clock_release);
      // pins left alone unless enabled as open-drain inputs
      if (!drive_ok || !active) begin
         d.oe = '0;
      end
      d.lvl = '0;                                             // open drain pulls low only
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         // bus seen idle high, clock released
         q.st        <= ISAR_ST_IDLE;
         q.kind      <= ISAR_K_FIRST;
         q.scl_sy    <= ISAR_SYNC_RST;
         q.sda_sy    <= ISAR_SYNC_RST;
         q.filt      <= '1;
         q.sr        <= ISAR_BYTE_RST;
         q.cnt       <= ISAR_CNT_RST;
         q.buf_r     <= ISAR_BYTE_RST;
         q.own       <= ISAR_BYTE_RST;
         q.bf        <= 1'b0;
         q.ov        <= 1'b0;
         q.irq       <= 1'b0;
         q.ua        <= 1'b0;
         q.rw        <= 1'b0;
         q.clock_release       <= 1'b1;
         q.match     <= 1'b0;
         q.irq_pend  <= 1'b0;
         q.tenbit_ok <= 1'b0;
         q.mst_ack   <= 1'b0;
         q.oe        <= '0;
         q.lvl       <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign scl_out              = q.lvl.scl;
   assign sda_out              = q.lvl.sda;
   assign scl_oe_out           = q.oe.scl;
   assign sda_oe_out           = q.oe.sda;
   assign transfer_buffer_out  = q.buf_r;
   assign own_address_out      = q.own;
   assign buffer_full_out      = q.bf;
   assign receive_overflow_out = q.ov;
   assign irq_flag_out         = q.irq;
   assign addr_update_out      = q.ua;
   assign rw_status_out        = q.rw;
   assign clock_release_out    = q.clock_release;

endmodule : isar_slave

// File: sim/isar_slave_monitor.sv
// concurrent checks on the i2c slave's pin drivers and firmware-side flags
// assumes the single clk_in domain with rst_in as its asynchronous reset
module isar_slave_monitor (
   input logic       clk_in,
   input logic       rst_in,
   input logic       port_enable_in,
   input logic       pin_dir_scl_in,
   input logic       pin_dir_sda_in,
   input logic       own_addr_wr_in,
   input logic [7:0] own_addr_data_in,
   input logic       buf_rd_in,
   input logic       buf_wr_in,
   input logic [7:0] buf_wdata_in,
   input logic       ov_clr_in,
   input logic       irq_clr_in,
   input logic       clock_release_set_in,
   input logic       scl_in,
   input logic       scl_out,
   input logic       scl_oe_out,
   input logic       sda_out,
   input logic       sda_oe_out,
   input logic [7:0] transfer_buffer_out,
   input logic [7:0] own_address_out,
   input logic       buffer_full_out,
   input logic       receive_overflow_out,
   input logic       irq_flag_out,
   input logic       addr_update_out,
   input logic       rw_status_out,
   input logic       clock_release_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] scl_hist_q;
   logic       quiet;
   // scl history: a flat stretch means no bus edge is in flight
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_hist_q <= 5'h1f;
      end else begin
         scl_hist_q <= {scl_hist_q[3:0], scl_in};
      end
   end
   assign quiet = (scl_hist_q == 5'h00) || (scl_hist_q == 5'h1f);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   od_low_a: assert property (!scl_out && !sda_out)
      else $error("pin data output not low");
   oe_gated_a: assert property ((scl_oe_out || sda_oe_out) |->
      $past(port_enable_in && pin_dir_scl_in && pin_dir_sda_in)) else $error("pin driven while off");
   rd_clears_a: assert property (buf_rd_in && !buf_wr_in && quiet |=> !buffer_full_out)
      else $error("buffer read left buffer full set");
   ov_hold_a: assert property (receive_overflow_out && !ov_clr_in && port_enable_in
      |=> receive_overflow_out) else $error("overflow cleared by itself");
   ov_clear_a: assert property (ov_clr_in && quiet |=> !receive_overflow_out)
      else $error("overflow not cleared");
   wr_full_a: assert property (buf_wr_in && !clock_release_out && !clock_release_set_in
      |=> buffer_full_out && transfer_buffer_out == $past(buf_wdata_in)) else $error("tx load lost");
   ua_clear_a: assert property (own_addr_wr_in && quiet |=> !addr_update_out &&
      own_address_out == $past(own_addr_data_in)) else $error("address write not taken");
   ckp_free_a: assert property (clock_release_set_in && !addr_update_out && quiet
      |=> clock_release_out && !scl_oe_out) else $error("clock not released");
   irq_hold_a: assert property (irq_flag_out && !irq_clr_in && port_enable_in
      |=> irq_flag_out) else $error("irq flag dropped by itself");
   ack_full_a: assert property ($rose(sda_oe_out) && !rw_status_out |->
      buffer_full_out ##1 sda_oe_out [*6]) else $error("ack without full buffer or too short");
   cover property ($rose(addr_update_out));
   cover property ($rose(receive_overflow_out));
   cover property ($fell(clock_release_out));
endmodule : isar_slave_monitor

bind isar_slave isar_slave_monitor i_mon (.*);

// File: sim/isar_master.sv
// behavioural i2c bus master: start, stop and byte transfers, 400 ns bit time
// assumes pull-ups on both lines; an oe output high pulls its line low
module isar_master (
   input  logic scl,
   input  logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus starts released, clock stands still outside frames
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // release scl and wait out a slave stretch, bounded
   task automatic rise();
      int n;
      n = 0;
      scl_oe = 1'b0;
      while (scl !== 1'b1 && n < 400) begin
         #50;
         n++;
      end
   endtask : rise
   // one bit: data set while scl low, sampled late in the high phase
   task automatic bitx(input logic b, input int pre, output logic s);
      #(pre + 50);
      sda_oe = !b;
      #150;
      rise();
      #190;
      s = sda;
      #10;
      scl_oe = 1'b1;
   endtask : bitx
   // eight bits msb first, then the ninth (ack) bit
   task automatic xfer(input logic [7:0] d, input logic n9, output logic [7:0] rx,
                       output logic s9);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], (i == 7) ? 200 : 0, s);
         rx = {rx[6:0], s};
      end
      bitx(n9, 200, s9);
      #50;
      sda_oe = 1'b0;
   endtask : xfer
   // start or repeated start: sda falls while scl high
   task automatic start();
      sda_oe = 1'b0;
      #100;
      rise();
      #100;
      sda_oe = 1'b1;
      #100;
      scl_oe = 1'b1;
   endtask : start
   // stop: sda rises while scl high
   task automatic stop();
      #50;
      sda_oe = 1'b1;
      #150;
      rise();
      #100;
      sda_oe = 1'b0;
      #200;
   endtask : stop
endmodule : isar_master

// File: sim/isar_slave_tb.sv
// self-checking bench for the i2c slave with a master model on the pins
// assumes the design's package is compiled first; firmware strobes are one-cycle pulses
module isar_slave_tb
   import isar_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       en = 1'b0;
   logic [3:0] mode = 4'h0;
   logic       dir_scl = 1'b1;
   logic       dir_sda = 1'b1;
   logic [5:0] stb = 6'h00;
   logic [7:0] fdat = 8'h00;
   logic       m_scl_oe, m_sda_oe, scl_oe, sda_oe, bf, ov, irq, ua, rw, clock_release;
   logic [7:0] tbuf, own;
   isar_pins_s bus_w;
   int         err_count = 0;
   int         total_checks = 0;
   int         cyc = 0;
   // wired-and bus with pull-ups
   assign bus_w = {~(m_scl_oe | scl_oe), ~(m_sda_oe | sda_oe)};
   always #25 clk_in = ~clk_in;
   isar_master i_mst (.scl(bus_w.scl), .sda(bus_w.sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   isar_slave i_dut (
      .clk_in(clk_in), .rst_in(rst_in), .port_enable_in(en), .mode_in(mode),
      .pin_dir_scl_in(dir_scl), .pin_dir_sda_in(dir_sda), .own_addr_wr_in(stb[5]),
      .own_addr_data_in(fdat), .buf_rd_in(stb[4]), .buf_wr_in(stb[3]), .buf_wdata_in(fdat),
      .ov_clr_in(stb[2]), .irq_clr_in(stb[1]), .clock_release_set_in(stb[0]),
      .scl_in(bus_w.scl), .sda_in(bus_w.sda), .scl_out(), .scl_oe_out(scl_oe), .sda_out(),
      .sda_oe_out(sda_oe), .transfer_buffer_out(tbuf), .own_address_out(own),
      .buffer_full_out(bf), .receive_overflow_out(ov), .irq_flag_out(irq),
      .addr_update_out(ua), .rw_status_out(rw), .clock_release_out(clock_release));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // strobes: own_wr, rd, wr, ov_clr, irq_clr, clock_release_set
   task automatic fw(input logic [5:0] s, input logic [7:0] d);
      @(posedge clk_in);
      stb <= s;
      fdat <= d;
      @(posedge clk_in);
      stb <= 6'h00;
      @(posedge clk_in);
      #1;
   endtask : fw
   // master writes a byte; a is high when the slave acked
   task automatic wr(input logic [7:0] b, output logic a);
      logic [7:0] rx;
      logic       s9;
      i_mst.xfer(b, 1'b1, rx, s9);
      a = !s9;
      repeat (8) @(posedge clk_in);
      #1;
   endtask : wr
   // disabled port, master modes and pins not inputs: no answer
   task automatic t_off();
      logic a;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in);
         en <= (i != 0);
         mode <= (i == 1) ? ISAR_MODE_MASTER : (i == 2) ? ISAR_MODE_FW_MST : ISAR_MODE_SLV7;
         dir_sda <= (i != 3);
         dir_scl <= (i != 4);
         fw(6'h20, 8'ha5);
         i_mst.start();
         wr(8'ha4, a);
         i_mst.stop();
         chk(a, 1'b0);
         if (i < 3) chk(irq, 1'b0);
         fw(6'h16, 8'h00);
      end
      $display("test off done");
   endtask : t_off
   // 7-bit receive with full buffer, overflow and stop interrupt
   task automatic t_7bit();
      logic       a;
      logic [3:0] m;
      for (int k = 0; k < 2; k++) begin
         m = k ? ISAR_MODE_SLV7_SS : ISAR_MODE_SLV7;
         @(posedge clk_in);
         mode <= m;
         fw(6'h16, 8'h00);
         i_mst.start();
         wr(8'ha4, a);
         chk({a, tbuf}, 9'h1a4);
         chk({bf, irq, rw}, 3'b110);
         fw(6'h02, 8'h00);
         wr(8'h11, a);
         chk({a, ov, irq, tbuf}, 11'h3a4);
         fw(6'h12, 8'h00);
         chk({bf, ov}, 2'b01);
         // refused data byte ends the frame: address again with overflow set
         i_mst.start();
         wr(8'ha4, a);
         chk({a, bf, irq}, 3'b001);
         fw(6'h06, 8'h00);
         chk(ov, 1'b0);
         i_mst.start();
         wr(8'ha4, a);
         fw(6'h10, 8'h00);
         wr(8'h3c, a);
         chk({a, tbuf}, 9'h13c);
         fw(6'h12, 8'h00);
         i_mst.stop();
         chk(irq, m == ISAR_MODE_SLV7_SS);
      end
      $display("test 7bit done");
   endtask : t_7bit
   // foreign address: no ack; start and stop flag only in their mode
   task automatic t_miss();
      logic       a;
      logic [3:0] m;
      for (int k = 0; k < 2; k++) begin
         m = k ? ISAR_MODE_SLV10_SS : ISAR_MODE_SLV7;
         @(posedge clk_in);
         mode <= m;
         fw(6'h16, 8'h00);
         i_mst.start();
         wr(8'h40, a);
         chk({a, irq}, {1'b0, m == ISAR_MODE_SLV10_SS});
         fw(6'h02, 8'h00);
         i_mst.stop();
         chk(irq, m == ISAR_MODE_SLV10_SS);
      end
      $display("test miss done");
   endtask : t_miss
   // 10-bit address, repeated start and slave transmit
   task automatic t_10bit();
      logic       a;
      logic       s9;
      logic [7:0] rx;
      @(posedge clk_in);
      mode <= ISAR_MODE_SLV10;
      fw(6'h20, 8'hf4);
      fw(6'h16, 8'h00);
      i_mst.start();
      wr(8'hf4, a);
      chk({a, bf, irq, ua, scl_oe}, 5'h1f);
      fw(6'h12, 8'h00);
      fw(6'h20, 8'h37);
      chk({ua, scl_oe}, 2'b00);
      wr(8'h37, a);
      chk({a, bf, irq, ua, scl_oe}, 5'h1f);
      fw(6'h12, 8'h00);
      fw(6'h20, 8'hf4);
      chk(scl_oe, 1'b0);
      i_mst.start();
      wr(8'hf5, a);
      chk({a, bf, irq, rw, clock_release}, 5'h1e);
      fw(6'h12, 8'h00);
      fw(6'h08, 8'h96);
      chk(bf, 1'b1);
      fw(6'h01, 8'h00);
      chk({clock_release, scl_oe}, 2'b10);
      i_mst.xfer(8'hff, 1'b1, rx, s9);
      chk(rx, 8'h96);
      i_mst.stop();
      $display("test 10bit done");
   endtask : t_10bit
   // main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      chk({clock_release, bf, ov, irq, ua, scl_oe, sda_oe}, 7'h40);
      t_off();
      @(posedge clk_in);
      en      <= 1'b1;
      dir_scl <= 1'b1;
      t_7bit();
      t_miss();
      t_10bit();
      end_sim();
   end
endmodule : isar_slave_tb
